//--- hdl/fcr_regs.vh
//
// Behaviour
// R01: configuration read accepted anytime, even busy; byte out on serial output.
// R02: opcodes 0x45 read config, 0x01 write status, 0x11 write config.
// R03: config bit 7 picks pin function: 0 hold input, 1 reset input.
// R04: quad enable set disables hold and reset, pin becomes plain data line.
// R05: config bit 4 is volatile page size: 0 gives 256, 1 gives 1024.
// R06: page size 0 wraps load address at 256; 1 uses full 1024.
// R07: with page size 1, page erase 0x81 clears a whole 1024 page.
// R08: config bit 2: 0 complement plus block bits, 1 individual locks.
// R09: every individual block lock bit is 1 after power-on or reset.
// R10: busy-watch 0x25 drives busy flag out while select stays low.
// R11: busy-watch output falls 1 to 0 at completion, never rises again.
// R12: host adds dummy bit in clock mode 3; none in mode 0.
// R13: raising select ends busy-watch and releases the serial output.
// R14: status or config writes need the write enable latch, else ignored.
// R15: status write leaves bits 15, 10, 1, 0 unchanged.
// R16: status write executes only if select rises after 8 or 16 bits.
// R17: 8-bit status write clears complement, quad enable, upper protect bit.
// R18: write cycle starts at select rise; busy during it; latch cleared after.
// R19: no status write while hardware-protected mode is in force.
// R20: config write needs exactly 8 bits, then timed cycle, latch cleared.
// R21: host should check busy flag clear before a new instruction.
// R22: busy flag is status bit 0, 1 while an operation runs.
// R23: latch at 0 refuses status write, program and erase.
// R24: hardware protect: upper bit 0, lower bit 1, write-protect pin low.
// R25: reserved config bits read 0, writes to them ignored.
`ifndef FCR_REGS_VH
`define FCR_REGS_VH
`define FCR_OP_RD_CFG   8'h45
`define FCR_OP_WR_STAT  8'h01
`define FCR_OP_WR_CFG   8'h11
`define FCR_OP_WATCH    8'h25
`define FCR_OP_WR_EN    8'h06
`define FCR_CFG_PINFN   7
`define FCR_CFG_PAGE    4
`define FCR_CFG_SCHEME  2
`define FCR_CFG_MASK    8'h94
`define FCR_CFG_RST     8'h00
`define FCR_ST_CMP      14
`define FCR_ST_QE       9
`define FCR_ST_SPHI     8
`define FCR_ST_SPLO     7
`define FCR_ST_MASK     16'h7bfc
`define FCR_ST_RST      16'h0000
`define FCR_TW_NS       1000000
`define FCR_CLK_MHZ     50
`define FCR_TW_CYC      ((`FCR_TW_NS * `FCR_CLK_MHZ) / 1000)
`endif

//--- hdl/fcr_top.v
`timescale 1ns/1ps
`include "fcr_regs.vh"
module fcr_top #(
  parameter              LOCK_W = 16,
  parameter [19:0]       TW_CYC = `FCR_TW_CYC
) (
  // clock and reset
  input  wire              I_CLK,
  input  wire              I_RST_B,
  // serial link
  input  wire              I_SCLK,
  input  wire              I_CS_B,
  input  wire [3:0]        I_IO,
  output reg  [3:0]        O_IO,
  output reg  [3:0]        O_IO_OE,
  // pins and core side
  input  wire              I_WP_B,
  input  wire              I_QPI,
  input  wire              I_OP_BUSY,
  // state toward the array logic
  output reg               O_BUSY,
  output reg               O_WEL,
  output reg  [15:0]       O_STATUS,
  output reg  [7:0]        O_CONFIG,
  output reg               O_HOLD_EN,
  output reg               O_RESET_EN,
  output reg  [9:0]        O_PAGE_MASK,
  output reg               O_ERASE_1K,
  output reg               O_INDIV_LOCK,
  output reg  [LOCK_W-1:0] O_BLOCK_LOCK
);

  localparam [2:0] ST_CMD  = 3'h0;
  localparam [2:0] ST_RCFG = 3'h1;
  localparam [2:0] ST_WAT  = 3'h2;
  localparam [2:0] ST_WST  = 3'h3;
  localparam [2:0] ST_WCF  = 3'h4;
  localparam [2:0] ST_WEN  = 3'h5;
  localparam [2:0] ST_IGN  = 3'h6;
  // select and write-protect idle high so reset gives no false edge
  localparam [6:0] SYNC_RST = 7'h42;

  function [2:0] fcr_dec;
    input [7:0] op;
    begin
      case (op)
        `FCR_OP_RD_CFG:  fcr_dec = ST_RCFG;
        `FCR_OP_WATCH:   fcr_dec = ST_WAT;
        `FCR_OP_WR_STAT: fcr_dec = ST_WST;
        `FCR_OP_WR_CFG:  fcr_dec = ST_WCF;
        `FCR_OP_WR_EN:   fcr_dec = ST_WEN;
        default:         fcr_dec = ST_IGN;
      endcase
    end
  endfunction

  reg  [6:0]        sync1_reg;
  reg  [6:0]        sync2_reg;
  reg               sclk_d_reg;
  reg               cs_d_reg;
  reg  [2:0]        state_reg;
  reg  [5:0]        cnt_reg;
  reg  [15:0]       sh_reg;
  reg  [7:0]        obuf_reg;
  reg  [15:0]       stat_reg;
  reg  [7:0]        cfg_reg;
  reg               wel_reg;
  reg  [19:0]       wcnt_reg;
  reg               watch_reg;
  reg  [LOCK_W-1:0] lock_reg;

  wire       sclk_s    = sync2_reg[0];
  wire       cs_s      = sync2_reg[1];
  wire [3:0] io_s      = sync2_reg[5:2];
  wire       wp_s      = sync2_reg[6];
  wire       sclk_rise = sclk_s & ~sclk_d_reg;
  wire       sclk_fall = ~sclk_s & sclk_d_reg;
  wire       cs_rise   = cs_s & ~cs_d_reg;
  wire       reg_busy  = (wcnt_reg != 20'h00000);
  wire       busy      = reg_busy | I_OP_BUSY;
  wire [5:0] step      = I_QPI ? 6'h04 : 6'h01;
  wire [5:0] cnt_add   = cnt_reg + step;
  wire [5:0] cnt_nx    = (cnt_reg > 6'h3b) ? cnt_reg : cnt_add;
  wire [15:0] sh_nx    = I_QPI ? {sh_reg[11:0], io_s} :
                                 {sh_reg[14:0], io_s[0]};
  wire [15:0] stat_rd  = {stat_reg[15:2], wel_reg, busy};
  // hardware protect, power lock-down and one-time lock all block status writes
  wire       hw_prot   = (~stat_reg[`FCR_ST_SPHI] & stat_reg[`FCR_ST_SPLO]
                          & ~wp_s) | stat_reg[`FCR_ST_SPHI]; // see R24
  wire       len8      = (cnt_reg == 6'h10);
  wire       len16     = (cnt_reg == 6'h18);
  wire       wr_ok     = wel_reg & ~busy; // see R14
  wire       wst_go    = (state_reg == ST_WST) & wr_ok & ~hw_prot
                         & (len8 | len16); // see R16 R19 R23
  wire       wcf_go    = (state_reg == ST_WCF) & wr_ok & len8; // see R20
  wire [15:0] st_data  = len16 ? {sh_reg[7:0], sh_reg[15:8]}
                               : {stat_reg[15:8], sh_reg[7:0]};
  wire [15:0] st_mask  = len16 ? `FCR_ST_MASK
                               : (`FCR_ST_MASK & 16'h00fc);
  reg  [15:0] stat_next;

  // an opcode is complete on the rising clock that brings its eighth bit
  wire       op_take   = ~cs_s & sclk_rise & (state_reg == ST_CMD)
                         & (cnt_nx == 6'h08);
  wire [2:0] op_state  = fcr_dec(sh_nx[7:0]); // see R02

  // next values of the serial output lines and their helpers
  reg  [3:0]  io_next;
  reg  [3:0]  oe_next;
  reg  [7:0]  obuf_next;
  reg         watch_next;

  always @* begin
    stat_next = (stat_reg & ~st_mask) | (st_data & st_mask); // see R15
    if (len8) begin
      stat_next[`FCR_ST_CMP]  = 1'b0; // see R17
      stat_next[`FCR_ST_QE]   = 1'b0;
      stat_next[`FCR_ST_SPHI] = 1'b0;
    end
  end

  // link pins and write-protect cross two flops before anything looks at them
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= {I_WP_B, I_IO, I_CS_B, I_SCLK};
      sync2_reg <= sync1_reg;
    end
  end

  // link front end: edge finders, bit counter, shifter, command state
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
      state_reg  <= ST_CMD;
      cnt_reg    <= 6'h00;
      sh_reg     <= 16'h0000;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_s;
      if (cs_s) begin
        // select high ends any command, even in mid-byte
        state_reg <= ST_CMD; // see R13
        cnt_reg   <= 6'h00;
      end else if (sclk_rise) begin
        cnt_reg <= cnt_nx;
        sh_reg  <= sh_nx;
        if (op_take)
          state_reg <= op_state; // see R02
      end
    end
  end

  // self-timed register write cycle, latch, status and config storage
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      stat_reg <= `FCR_ST_RST;
      cfg_reg  <= `FCR_CFG_RST;
      wel_reg  <= 1'b0;
      wcnt_reg <= 20'h00000;
      lock_reg <= {LOCK_W{1'b1}}; // see R09
    end else begin
      if (reg_busy) begin
        wcnt_reg <= wcnt_reg - 20'h00001;
        if (wcnt_reg == 20'h00001)
          wel_reg <= 1'b0; // see R18 R20
      end
      if (cs_rise) begin
        if (wst_go) begin
          stat_reg <= stat_next;
          wcnt_reg <= TW_CYC; // see R18
        end
        if (wcf_go) begin
          // reserved bits never stored
          cfg_reg  <= sh_reg[7:0] & `FCR_CFG_MASK; // see R25
          wcnt_reg <= TW_CYC; // see R20
        end
        // a set in the clock that ends a cycle wins over the clear
        if ((state_reg == ST_WEN) && (cnt_reg == 6'h08))
          wel_reg <= 1'b1;
      end
    end
  end

  // serial output lines: config readout and busy watch
  always @* begin
    io_next    = O_IO;
    oe_next    = O_IO_OE;
    obuf_next  = obuf_reg;
    watch_next = watch_reg;
    if (cs_s) begin
      // select high releases the lines one clock after it is seen
      watch_next = 1'b0;
      io_next    = 4'h0;
      oe_next    = 4'h0; // see R13
    end else begin
      if (op_take) begin
        obuf_next = cfg_reg; // see R01
        if (op_state == ST_WAT) begin
          // no clock needed after the opcode; mode 3 hosts pad it
          watch_next = busy; // see R10 R12
          io_next    = {2'h0, busy, 1'b0};
          oe_next    = 4'h2;
        end
      end
      if (sclk_fall && (state_reg == ST_RCFG)) begin
        // config byte repeats for as long as the host clocks
        if (I_QPI) begin
          io_next   = obuf_reg[7:4];
          oe_next   = 4'hf;
          obuf_next = {obuf_reg[3:0], obuf_reg[7:4]};
        end else begin
          io_next   = {2'h0, obuf_reg[7], 1'b0}; // see R01
          oe_next   = 4'h2;
          obuf_next = {obuf_reg[6:0], obuf_reg[7]};
        end
      end
      if (state_reg == ST_WAT) begin
        // once low it stays low for the rest of the command
        watch_next = watch_reg & busy; // see R11
        io_next    = {2'h0, watch_reg & busy, 1'b0}; // see R10 R11
        oe_next    = 4'h2;
      end
    end
  end

  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      obuf_reg  <= 8'h00;
      watch_reg <= 1'b0;
      O_IO      <= 4'h0;
      O_IO_OE   <= 4'h0;
    end else begin
      obuf_reg  <= obuf_next;
      watch_reg <= watch_next;
      O_IO      <= io_next;
      O_IO_OE   <= oe_next;
    end
  end

  // status and pin-function outputs, one cycle behind the registers
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_BUSY       <= 1'b0;
      O_WEL        <= 1'b0;
      O_STATUS     <= 16'h0000;
      O_CONFIG     <= 8'h00;
      O_HOLD_EN    <= 1'b0;
      O_RESET_EN   <= 1'b0;
      O_PAGE_MASK  <= 10'h0ff;
      O_ERASE_1K   <= 1'b0;
      O_INDIV_LOCK <= 1'b0;
      O_BLOCK_LOCK <= {LOCK_W{1'b1}};
    end else begin
      O_BUSY       <= busy; // see R22
      O_WEL        <= wel_reg; // see R23
      O_STATUS     <= stat_rd; // see R22
      O_CONFIG     <= cfg_reg; // see R25
      O_HOLD_EN    <= ~stat_reg[`FCR_ST_QE]
                      & ~cfg_reg[`FCR_CFG_PINFN]; // see R03 R04
      O_RESET_EN   <= ~stat_reg[`FCR_ST_QE]
                      & cfg_reg[`FCR_CFG_PINFN]; // see R03 R04
      O_PAGE_MASK  <= cfg_reg[`FCR_CFG_PAGE] ? 10'h3ff
                                             : 10'h0ff; // see R05 R06
      O_ERASE_1K   <= cfg_reg[`FCR_CFG_PAGE]; // see R07
      O_INDIV_LOCK <= cfg_reg[`FCR_CFG_SCHEME]; // see R08
      O_BLOCK_LOCK <= lock_reg; // see R09
    end
  end

endmodule

//--- test/fcr_host.sv
`timescale 1ns/1ps
module fcr_host (
  // link toward the device
  input  wire       i_clk,
  input  wire       i_so,
  output reg        o_sclk,
  output reg        o_cs_b,
  output reg  [3:0] o_io
);
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_io   = 4'h0;
  end
  // mode 0 only, so no dummy bit follows the watch opcode; sclk parks low
  task automatic shift(input [31:0] d, input int n, input bit keep,
                       output [31:0] q);
    q = 32'h0;
    @(negedge i_clk);
    o_cs_b = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      o_io[0] = d[i];
      #80;
      o_sclk = 1'b1;
      q = {q[30:0], i_so};
      #80;
      o_sclk = 1'b0;
    end
    #80;
    if (!keep) drop();
  endtask
  // released lines show the inverse so a stale value is never trusted
  task automatic drop;
    o_cs_b = 1'b1;
    o_io   = ~o_io;
    #160;
  endtask
endmodule

//--- test/fcr_top_properties.sv
`timescale 1ns/1ps
module fcr_chk #(
  parameter        LOCK_W = 16,
  parameter [19:0] TW_CYC = 20
) (
  // watched ports
  input wire              I_CLK,
  input wire              I_RST_B,
  input wire              I_CS_B,
  input wire [3:0]        O_IO_OE,
  input wire              O_BUSY,
  input wire              O_WEL,
  input wire [15:0]       O_STATUS,
  input wire [7:0]        O_CONFIG,
  input wire              O_HOLD_EN,
  input wire              O_RESET_EN,
  input wire [9:0]        O_PAGE_MASK,
  input wire              O_ERASE_1K,
  input wire              O_INDIV_LOCK,
  input wire [LOCK_W-1:0] O_BLOCK_LOCK
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  // derived outputs lag their source by a cycle, so wait for it to settle
  sequence s_settled;
    $past(I_RST_B, 2) && $stable(O_CONFIG) && $stable(O_STATUS);
  endsequence
  sequence s_write_cycle;
    O_BUSY [*8] ##[1:400] !O_BUSY;
  endsequence
  a_idle_release: assert property (I_CS_B [*5] |-> O_IO_OE == 4'h0)
    else $error("output enabled while deselected");
  a_pin_function: assert property (s_settled |->
    O_HOLD_EN == (!O_STATUS[9] && !O_CONFIG[7]) &&
    O_RESET_EN == (!O_STATUS[9] && O_CONFIG[7]))
    else $error("pin function wrong");
  a_page_size: assert property (s_settled |->
    O_PAGE_MASK == (O_CONFIG[4] ? 10'h3ff : 10'h0ff) &&
    O_ERASE_1K == O_CONFIG[4]) else $error("page size wrong");
  a_lock_scheme: assert property (s_settled |->
    O_INDIV_LOCK == O_CONFIG[2]) else $error("scheme wrong");
  a_lock_ones: assert property (O_BLOCK_LOCK == {LOCK_W{1'b1}})
    else $error("block lock not set");
  a_cfg_reserved: assert property ((O_CONFIG & 8'h6b) == 8'h00)
    else $error("reserved config bit set");
  a_status_fixed: assert property (!O_STATUS[15] && !O_STATUS[10])
    else $error("fixed status bit changed");
  a_busy_bit: assert property ($past(I_RST_B) |-> O_STATUS[0] == O_BUSY)
    else $error("busy bit differs");
  a_cycle_len: assert property ($rose(O_BUSY) && O_WEL |-> s_write_cycle)
    else $error("write cycle length wrong");
  a_wel_clear: assert property ($fell(O_BUSY) |-> !O_WEL)
    else $error("latch kept after cycle");
endmodule

//--- test/test_flash_config_status_write_cmds.sv
`timescale 1ns/1ps
module test_flash_config_status_write_cmds;
  logic        clk, rst_b, wp_b, op_busy, busy, write_enable_latch, hold, rst_en;
  logic        e1k, indiv, sclk, cs_b;
  logic [3:0]  io, o_io, oe;
  logic [15:0] status, lock;
  logic [7:0]  cfg;
  logic [9:0]  pmask;
  logic [31:0] q;
  int          errors = 0;
  int          checks = 0;
  int          cyc = 0;
  fcr_top #(.LOCK_W(16), .TW_CYC(20'd200)) uut (
    .I_CLK(clk), .I_RST_B(rst_b), .I_SCLK(sclk), .I_CS_B(cs_b),
    .I_IO(io), .O_IO(o_io), .O_IO_OE(oe), .I_WP_B(wp_b), .I_QPI(1'b0),
    .I_OP_BUSY(op_busy), .O_BUSY(busy), .O_WEL(write_enable_latch), .O_STATUS(status),
    .O_CONFIG(cfg), .O_HOLD_EN(hold), .O_RESET_EN(rst_en),
    .O_PAGE_MASK(pmask), .O_ERASE_1K(e1k), .O_INDIV_LOCK(indiv),
    .O_BLOCK_LOCK(lock));
  fcr_host host (.i_clk(clk), .i_so(o_io[1]), .o_sclk(sclk),
    .o_cs_b(cs_b), .o_io(io));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input bit en, input [7:0] op, input [15:0] d,
                    input int n);
    int k;
    if (en) host.shift(32'h6, 8, 1'b0, q);
    host.shift((32'(op) << n) | 32'(d), n + 8, 1'b0, q);
    k = 0;
    while (busy !== 1'b0 && k < 400) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic t_reset;
    check(cfg, 8'h00);
    check(lock, 16'hffff);
    check(pmask, 10'h0ff);
    check({hold, rst_en}, 2'b10);
    $display("t_reset done");
  endtask
  task automatic t_config;
    wr(1, 8'h11, 16'hff, 8);
    check(cfg, 8'h94);
    check({write_enable_latch, rst_en, hold, e1k, indiv}, 5'b01011);
    check(pmask, 10'h3ff);
    op_busy = 1'b1;
    host.shift(32'h4500, 16, 1'b0, q);
    op_busy = 1'b0;
    check(q[7:0], 8'h94);
    wr(0, 8'h11, 16'h0, 8);
    check(cfg, 8'h94);
    wr(1, 8'h11, 16'h0, 9);
    check(cfg, 8'h94);
    wr(0, 8'h11, 16'h0, 8);
    check(cfg, 8'h00);
    $display("t_config done");
  endtask
  task automatic t_status;
    wr(1, 8'h01, 16'h7ffe, 16);
    check(status, 16'h7a7c);
    check({hold, rst_en}, 2'b00);
    wr(1, 8'h01, 16'h0, 12);
    check(status, 16'h7a7e);
    wr(1, 8'h01, 16'h7c, 8);
    check(status, 16'h387c);
    wr(1, 8'h01, 16'h80, 8);
    wp_b = 1'b0;
    wr(1, 8'h01, 16'h0, 8);
    check(status, 16'h3882);
    wp_b = 1'b1;
    wr(1, 8'h01, 16'h0, 8);
    check(status, 16'h3800);
    $display("t_status done");
  endtask
  task automatic t_watch;
    logic seen;
    int   k;
    host.shift(32'h6, 8, 1'b0, q);
    host.shift(32'h100, 16, 1'b0, q);
    host.shift(32'h25, 8, 1'b1, q);
    check({oe[1], o_io[1]}, 2'b11);
    k = 0;
    while (o_io[1] !== 1'b0 && k < 400) begin
      @(negedge clk);
      k++;
    end
    seen = 1'b0;
    repeat (20) begin
      @(negedge clk);
      seen = seen | o_io[1];
    end
    check({oe[1], seen}, 2'b10);
    host.drop();
    check(oe, 4'h0);
    $display("t_watch done");
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    op_busy = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_config();
    t_status();
    t_watch();
    complete_run();
  end
endmodule
bind fcr_top fcr_chk #(.LOCK_W(LOCK_W), .TW_CYC(TW_CYC)) chk (
  .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CS_B(I_CS_B), .O_IO_OE(O_IO_OE),
  .O_BUSY(O_BUSY), .O_WEL(O_WEL), .O_STATUS(O_STATUS),
  .O_CONFIG(O_CONFIG), .O_HOLD_EN(O_HOLD_EN), .O_RESET_EN(O_RESET_EN),
  .O_PAGE_MASK(O_PAGE_MASK), .O_ERASE_1K(O_ERASE_1K),
  .O_INDIV_LOCK(O_INDIV_LOCK), .O_BLOCK_LOCK(O_BLOCK_LOCK));
